// file: rtl/tsl_lamp_ctrl.sv
// Turn signal, hazard, brake and parking lamp controller
`timescale 1ns/1ps
// Overview of operation
// [RULE1] Lever centre means no turn; up/down pick side
// [RULE2] Turning side's rear lamp blinks
// [RULE3] Turning side's front and dash lamps blink
// [RULE4] Hazard switch blinks all six lamps; brake holds non-turning rear lamps steady instead
// [RULE5] Brake holds rear lamps on unless turning
// [RULE6] Brake never touches front or dash lamps
// [RULE7] Blinking passes the slow flash wave through
// [RULE8] System supplies flash wave and dimming carrier
// [RULE9] Parking switch gates carrier onto exterior lamps
// [RULE10] Dashboard lamps never carry parking glow
// [RULE11] Six separate lamp outputs, three per side
// [RULE12] Dark exterior lamp shows carrier while parking
module tsl_lamp_ctrl
	import tsl_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic lever_up,
	input wire logic lever_down,
	input wire logic hazard_request,
	input wire logic brake_switch,
	input wire logic park_switch,
	input wire logic flash_wave,
	input wire logic dim_wave,
	output logic lamp_left_front,
	output logic lamp_left_rear,
	output logic lamp_left_dash,
	output logic lamp_right_front,
	output logic lamp_right_rear,
	output logic lamp_right_dash
);

	logic rst_sync_n;

	// Lamps go dark at once on reset but wake only on a clock edge
	tsl_rst_sync u_rst_sync (
		.clk(clk),
		.rst_n(rst_n),
		.rst_sync_n(rst_sync_n)
	);

	// Lever decode; both contacts closed cannot happen on a
	// single-pole lever, so it is taken as a fault and means no turn
	function automatic tsl_turn_t tsl_lever_decode(
		input logic up,
		input logic down
	);
		tsl_turn_t turn;
		// Both contacts closed is the one illegal code
		unique case ({up, down})
			2'h0: begin
				turn = TSL_TURN_NONE; // see [RULE1]
			end
			2'h1: begin
				turn = TSL_TURN_LEFT; // see [RULE1]
			end
			2'h2: begin
				turn = TSL_TURN_RIGHT; // see [RULE1]
			end
			default: begin
				turn = TSL_TURN_NONE;
			end
		endcase
		return turn;
	endfunction

	// Lamp group of one side: front, rear, dash
	function automatic logic [TSL_SIDE_W-1:0] tsl_side_lamps(
		input logic turning,
		input logic hazard,
		input logic brake,
		input logic park,
		input logic flash,
		input logic dim
	);
		logic [TSL_SIDE_W-1:0] lamps;
		logic blink_sel;
		logic front;
		logic rear;
		logic dash;
		logic glow;

		lamps = '0;
		blink_sel = turning || hazard;
		glow = park && dim; // see [RULE9]

		// Front and dash follow only turn and hazard
		front = blink_sel && flash; // see [RULE3] see [RULE4] see [RULE6] see [RULE7]
		dash = blink_sel && flash; // see [RULE3] see [RULE4] see [RULE6] see [RULE7]

		// Own turn beats brake; brake beats hazard on the rear
		if (turning) begin
			rear = flash; // see [RULE2] see [RULE5] see [RULE7]
		end else if (brake) begin
			rear = 1'h1; // see [RULE5]
		end else begin
			rear = hazard && flash; // see [RULE4] see [RULE7]
		end

		// Glow only fills dark phases, so a lit filament stays fully lit
		front = front || glow; // see [RULE9] see [RULE12]
		rear = rear || glow; // see [RULE9] see [RULE12]

		lamps[TSL_POS_FRONT] = front;
		lamps[TSL_POS_REAR] = rear;
		lamps[TSL_POS_DASH] = dash; // see [RULE10]
		return lamps;
	endfunction

	// Input sample group
	logic up_ff;
	logic down_ff;
	logic hazard_ff;
	logic brake_ff;
	logic park_ff;
	logic flash_ff;
	logic dim_ff;

	logic nxt_up;
	logic nxt_down;
	logic nxt_hazard;
	logic nxt_brake;
	logic nxt_park;
	logic nxt_flash;
	logic nxt_dim;

	// Both waves are free-running from outside and only gated here
	always_comb begin
		nxt_up = lever_up;
		nxt_down = lever_down;
		nxt_hazard = hazard_request;
		nxt_brake = brake_switch;
		nxt_park = park_switch;
		nxt_flash = flash_wave; // see [RULE8]
		nxt_dim = dim_wave; // see [RULE8]
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			up_ff <= TSL_SW_RST;
			down_ff <= TSL_SW_RST;
			hazard_ff <= TSL_SW_RST;
			brake_ff <= TSL_SW_RST;
			park_ff <= TSL_SW_RST;
			flash_ff <= TSL_SW_RST;
			dim_ff <= TSL_SW_RST;
		end else begin
			up_ff <= nxt_up;
			down_ff <= nxt_down;
			hazard_ff <= nxt_hazard;
			brake_ff <= nxt_brake;
			park_ff <= nxt_park;
			flash_ff <= nxt_flash;
			dim_ff <= nxt_dim;
		end
	end

	// Lamp output group
	tsl_turn_t turn;
	logic [TSL_SIDE_W-1:0] left_lamps;
	logic [TSL_SIDE_W-1:0] right_lamps;
	logic turn_left;
	logic turn_right;
	logic nxt_left_front;
	logic nxt_left_rear;
	logic nxt_left_dash;
	logic nxt_right_front;
	logic nxt_right_rear;
	logic nxt_right_dash;

	logic left_front_ff;
	logic left_rear_ff;
	logic left_dash_ff;
	logic right_front_ff;
	logic right_rear_ff;
	logic right_dash_ff;

	always_comb begin
		turn = tsl_lever_decode(up_ff, down_ff);
		turn_left = (turn == TSL_TURN_LEFT); // see [RULE1]
		turn_right = (turn == TSL_TURN_RIGHT); // see [RULE1]

		left_lamps = tsl_side_lamps(turn_left, hazard_ff, brake_ff,
			park_ff, flash_ff, dim_ff);
		right_lamps = tsl_side_lamps(turn_right, hazard_ff, brake_ff,
			park_ff, flash_ff, dim_ff);

		nxt_left_front = left_lamps[TSL_POS_FRONT]; // see [RULE11]
		nxt_left_rear = left_lamps[TSL_POS_REAR]; // see [RULE11]
		nxt_left_dash = left_lamps[TSL_POS_DASH]; // see [RULE11]
		nxt_right_front = right_lamps[TSL_POS_FRONT]; // see [RULE11]
		nxt_right_rear = right_lamps[TSL_POS_REAR]; // see [RULE11]
		nxt_right_dash = right_lamps[TSL_POS_DASH]; // see [RULE11]
	end

	// Registered so lamp drivers never see decode glitches
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			left_front_ff <= TSL_LAMP_RST;
			left_rear_ff <= TSL_LAMP_RST;
			left_dash_ff <= TSL_LAMP_RST;
			right_front_ff <= TSL_LAMP_RST;
			right_rear_ff <= TSL_LAMP_RST;
			right_dash_ff <= TSL_LAMP_RST;
		end else begin
			left_front_ff <= nxt_left_front;
			left_rear_ff <= nxt_left_rear;
			left_dash_ff <= nxt_left_dash;
			right_front_ff <= nxt_right_front;
			right_rear_ff <= nxt_right_rear;
			right_dash_ff <= nxt_right_dash;
		end
	end

	assign lamp_left_front = left_front_ff;
	assign lamp_left_rear = left_rear_ff;
	assign lamp_left_dash = left_dash_ff;
	assign lamp_right_front = right_front_ff;
	assign lamp_right_rear = right_rear_ff;
	assign lamp_right_dash = right_dash_ff;

endmodule

// file: rtl/tsl_pkg.sv
// Shared constants and types for the turn signal lamp controller
package tsl_pkg;

	// Decoded turn lever position; Gray order none, left, right
	typedef enum logic [1:0] {
		TSL_TURN_NONE = 2'h0,
		TSL_TURN_LEFT = 2'h1,
		TSL_TURN_RIGHT = 2'h3
	} tsl_turn_t;

	// Value of every lamp and sampled switch after reset
	localparam logic TSL_LAMP_RST = 1'h0;
	localparam logic TSL_SW_RST = 1'h0;
	localparam tsl_turn_t TSL_TURN_RST = TSL_TURN_NONE;

	// Depth of the reset release chain
	localparam int TSL_RST_STAGES = 2;

	// Bit positions inside one side's lamp group
	localparam int TSL_POS_FRONT = 2;
	localparam int TSL_POS_REAR = 1;
	localparam int TSL_POS_DASH = 0;
	localparam int TSL_SIDE_W = 3;

endpackage

// file: rtl/tsl_rst_sync.sv
// Reset release synchroniser for the turn signal lamp controller
`timescale 1ns/1ps
module tsl_rst_sync
	import tsl_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	output logic rst_sync_n
);

	logic [TSL_RST_STAGES-1:0] chain_ff;
	logic [TSL_RST_STAGES-1:0] nxt_chain;

	// Assert at once, release only after the chain fills with ones
	always_comb begin
		nxt_chain = {chain_ff[TSL_RST_STAGES-2:0], 1'h1};
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chain_ff <= '0;
		end else begin
			chain_ff <= nxt_chain;
		end
	end

	assign rst_sync_n = chain_ff[TSL_RST_STAGES-1];

endmodule

// file: dv/tsl_wave_gen.sv
// Flash and dimming oscillators for the lamp bench
`timescale 1ns/1ps
module tsl_wave_gen #(parameter int FLASH_HALF = 8) (
	input wire logic clk,
	output logic flash_wave = 1'h0,
	output logic dim_wave = 1'h0
);
	int cnt = 0;
	// Free running, no reset
	always @(posedge clk) begin
		dim_wave <= ~dim_wave;
		cnt <= (cnt == FLASH_HALF - 1) ? 0 : cnt + 1;
		if (cnt == FLASH_HALF - 1) flash_wave <= ~flash_wave;
	end
endmodule

// file: dv/tsl_lamp_properties.sv
// Lamp controller assertions
`timescale 1ns/1ps
module tsl_lamp_properties (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic lever_up,
	input wire logic lever_down,
	input wire logic hazard_request,
	input wire logic brake_switch,
	input wire logic park_switch,
	input wire logic flash_wave,
	input wire logic dim_wave,
	input wire logic lamp_left_front,
	input wire logic lamp_left_rear,
	input wire logic lamp_left_dash,
	input wire logic lamp_right_front,
	input wire logic lamp_right_rear,
	input wire logic lamp_right_dash
);
	logic [2:0] cnt_ff;
	logic [2:0] nxt_cnt;
	logic ok;
	// Lamps lag the reset release chain
	always_comb begin
		nxt_cnt = (cnt_ff == 3'h7) ? cnt_ff : cnt_ff + 3'h1;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 3'h0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
	assign ok = cnt_ff >= 3'h4;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_centre_no_turn: assert property (
		ok && $past(!lever_up && !lever_down && !hazard_request, 2)
		|-> !lamp_left_dash && !lamp_right_dash) else $error("dash lit");
	a_left_rear_blink: assert property (
		ok && $past(lever_down && !lever_up, 2)
		|-> lamp_left_rear == $past(flash_wave | (park_switch & dim_wave), 2))
		else $error("left rear");
	a_right_dash_blink: assert property (
		ok && $past(lever_up && !lever_down, 2)
		|-> lamp_right_dash == $past(flash_wave, 2)) else $error("right dash");
	a_hazard_all_on: assert property (
		ok && $past(hazard_request && flash_wave, 2)
		|-> lamp_left_front && lamp_left_rear && lamp_left_dash && lamp_right_front
		&& lamp_right_rear && lamp_right_dash) else $error("hazard");
	a_brake_rear_on: assert property (
		ok && $past(brake_switch && !lever_up, 2)
		|-> lamp_right_rear) else $error("brake rear");
	a_brake_no_front: assert property (
		ok && $past(!lever_up && !lever_down && !hazard_request && !park_switch, 2)
		|-> !lamp_left_front && !lamp_right_front) else $error("front");
	a_flash_dark: assert property (
		ok && $past(!flash_wave && !park_switch && !brake_switch, 2)
		|-> !lamp_left_rear && !lamp_right_front) else $error("dark");
	a_park_glow: assert property (
		ok && $past(park_switch && dim_wave, 2)
		|-> lamp_left_front && lamp_right_rear) else $error("glow");
	a_dash_no_glow: assert property (
		ok && $past(!flash_wave, 2)
		|-> !lamp_left_dash && !lamp_right_dash) else $error("dash glow");
	a_dark_carrier: assert property (
		ok && $past(park_switch && !flash_wave && !brake_switch, 2)
		|-> lamp_left_rear == $past(dim_wave, 2)) else $error("carrier");
endmodule
bind tsl_lamp_ctrl tsl_lamp_properties i_tsl_lamp_properties (.clk, .rst_n, .lever_up,
	.lever_down, .hazard_request, .brake_switch, .park_switch, .flash_wave, .dim_wave,
	.lamp_left_front, .lamp_left_rear, .lamp_left_dash, .lamp_right_front,
	.lamp_right_rear, .lamp_right_dash);

// file: dv/tb_top.sv
// Lamp controller testbench
`timescale 1ns/1ps
module tb_top;
	logic clk = 0, rst_n = 0, up = 0, dn = 0, haz = 0, brk = 0, park = 0;
	logic flash, dim;
	logic [6:0] d1 = 0, d2 = 0;
	wire [5:0] lamps;
	int failures = 0, check_count = 0;
	always #25 clk = ~clk;
	tsl_wave_gen i_tsl_wave_gen (.clk, .flash_wave(flash), .dim_wave(dim));
	tsl_lamp_ctrl i_tsl_lamp_ctrl (.clk, .rst_n, .lever_up(up), .lever_down(dn),
		.hazard_request(haz), .brake_switch(brk), .park_switch(park), .flash_wave(flash),
		.dim_wave(dim), .lamp_left_front(lamps[5]), .lamp_left_rear(lamps[4]),
		.lamp_left_dash(lamps[3]), .lamp_right_front(lamps[2]), .lamp_right_rear(lamps[1]),
		.lamp_right_dash(lamps[0]));
	// Two-stage lag of the lamp path
	always @(posedge clk) begin
		d1 <= {up, dn, haz, brk, park, flash, dim};
		d2 <= d1;
	end
	function automatic logic [5:0] ref_lamps(input logic [6:0] v);
		logic l, r, g;
		l = v[5] & !v[6];
		r = v[6] & !v[5];
		g = v[2] & v[0];
		return {((l | v[4]) & v[1]) | g, (l ? v[1] : v[3] | (v[4] & v[1])) | g,
			(l | v[4]) & v[1], ((r | v[4]) & v[1]) | g,
			(r ? v[1] : v[3] | (v[4] & v[1])) | g, (r | v[4]) & v[1]};
	endfunction
	task chk(input logic [5:0] got, input logic [5:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t lamps %b want %b", $time, got, exp);
		end
	endtask
	task go(input string name, input logic [4:0] s);
		@(posedge clk);
		{up, dn, haz, brk, park} <= s;
		repeat (40) begin
			@(negedge clk);
			chk(lamps, ref_lamps(d2));
		end
		$display("test %s done", name);
	endtask
	task t_left; go("left", 5'h08); endtask
	task t_right; go("right", 5'h10); endtask
	task t_both; go("both", 5'h18); endtask
	task t_hazard; go("hazard", 5'h0C); endtask
	task t_haz_only; go("haz_only", 5'h04); endtask
	task t_brake; go("brake", 5'h02); endtask
	task t_brake_turn; go("brake_turn", 5'h0A); endtask
	task t_brake_haz; go("brake_haz", 5'h16); endtask
	task t_park; go("park", 5'h01); endtask
	task t_park_mix; go("park_mix", 5'h0B); endtask
	// Mid-run reset darkens lamps at once and keeps them dark through release
	task t_reset;
		@(posedge clk);
		{up, dn, haz, brk, park} <= 5'h05;
		repeat (20) @(posedge clk);
		rst_n <= 1'h0;
		repeat (3) begin
			@(negedge clk);
			chk(lamps, 6'h00);
		end
		@(posedge clk);
		rst_n <= 1'h1;
		repeat (3) begin
			@(negedge clk);
			chk(lamps, 6'h00);
		end
		repeat (6) @(posedge clk);
		$display("test %s done", "reset");
	endtask
	task final_report;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1;
		repeat (6) @(posedge clk);
		t_left;
		t_right;
		t_both;
		t_hazard;
		t_haz_only;
		t_brake;
		t_reset;
		t_brake_turn;
		t_brake_haz;
		t_park;
		t_park_mix;
		final_report;
	end
	// About 500 cycles expected
	initial begin
		#100000;
		failures++;
		final_report;
	end
endmodule
